// ==== rtl/pcsr_pkg.sv ====
// Package for the per-function bus command and status register bank
package pcsr_pkg;
	localparam logic [7:0] PCSR_OFS_CMD = 8'h04;
	localparam logic [7:0] PCSR_OFS_STS = 8'h06;
	localparam logic [15:0] PCSR_CMD_RST = 16'h0000;
	localparam logic [15:0] PCSR_STS_RST = 16'h0210;
	// Command bit positions
	localparam int PCSR_B_IO = 0;
	localparam int PCSR_B_MEM = 1;
	localparam int PCSR_B_INIT = 2;
	localparam int PCSR_B_PAR = 6;
	localparam int PCSR_B_SYS = 8;
	// Writable command bits: 8, 6, 2, 1, 0
	localparam logic [15:0] PCSR_CMD_WMASK = 16'h0147;
	// Status flag positions (write one to clear)
	localparam int PCSR_S_DPAR = 8;
	localparam int PCSR_S_TABS = 11;
	localparam int PCSR_S_TABR = 12;
	localparam int PCSR_S_MABT = 13;
	localparam int PCSR_S_SERR = 14;
	localparam int PCSR_S_PERR = 15;
	localparam logic [15:0] PCSR_STS_W1C = 16'hf900;
	// Hardwired status: decode timing 01b in 10:9, capability list in 4
	localparam logic [15:0] PCSR_STS_FIXED = 16'h0210;

	typedef struct packed {
		logic [15:0] addr_parity_error_seen; // address parity error seen, per fn
		logic data_parity_error_seen;        // data parity error seen
		logic master_data_perr;    // we mastered the failing data phase
		logic master_abort;        // master abort received
		logic target_abort_rx;     // target abort received
		logic target_abort_tx;     // target abort signalled
	} pcsr_evt_s;

	typedef struct packed {
		logic [1:0][15:0] cmd_r;   // writable command bits per function
		logic [1:0][15:0] sts_r;   // sticky status flags per function
		logic [15:0] rdata_r;
		logic serr_oe_r;
		logic perr_oe_r;
		logic [1:0] mem_en_r;
		logic [1:0] io_en_r;
		logic [1:0] init_en_r;
	} pcsr_state_s;
endpackage

// ==== rtl/pcsr_regs.sv ====
// Command and status registers of both bridge functions
`timescale 1ns/1ps
`default_nettype none
module pcsr_regs
	import pcsr_pkg::*;
(
	input wire logic REF_CLK,                 // bus clock
	input wire logic RST_B,                   // synchronous reset, low
	input wire logic CFG_WR,                  // config write strobe
	input wire logic CFG_RD,                  // config read strobe
	input wire logic CFG_FN,                  // function number 0/1
	input wire logic [7:0] CFG_ADDR,          // config word byte offset
	input wire logic [15:0] CFG_WDATA,        // config write data
	input wire logic [1:0] CFG_BE,            // byte enables
	input wire pcsr_pkg::pcsr_evt_s EVT_F0,   // error events, function 0
	input wire pcsr_pkg::pcsr_evt_s EVT_F1,   // error events, function 1
	output logic [15:0] CFG_RDATA,            // registered read data
	output logic SERR_OE,                     // system error driver on
	output logic PERR_OE,                     // parity error driver on
	output logic [1:0] MEM_CLAIM_EN,          // memory decode allowed
	output logic [1:0] IO_CLAIM_EN,           // I/O decode allowed
	output logic [1:0] INITIATOR_EN           // bus request allowed
);
	import pcsr_pkg::*;

	pcsr_state_s s_r;
	pcsr_state_s s_nxt;

	// Byte enable 0 covers the low byte, byte enable 1 the high byte
	function automatic logic [15:0] lane_mask(
		input logic [1:0] be
	);
		logic [15:0] m;
		m = 16'h0000;
		if (be[0]) begin
			m[7:0] = 8'hff;
		end
		if (be[1]) begin
			m[15:8] = 8'hff;
		end
		lane_mask = m;
	endfunction

	// Hardwired command bits never take a value, whatever is written
	function automatic logic [15:0] cmd_merge(
		input logic [15:0] old_val,
		input logic [15:0] wdata,
		input logic [15:0] lanes
	);
		logic [15:0] sel;
		sel = lanes & PCSR_CMD_WMASK;
		cmd_merge = (old_val & ~sel) | (wdata & sel);
	endfunction

	// Next command word of one function
	function automatic logic [15:0] cmd_next(
		input logic [15:0] old_val,
		input logic wr,
		input logic [15:0] wdata,
		input logic [15:0] lanes
	);
		logic [15:0] v;
		v = old_val;
		if (wr) begin
			v = cmd_merge(old_val, wdata, lanes);
		end
		cmd_next = v;
	endfunction

	// Ones clear flags; zeros and the fixed fields are left alone
	function automatic logic [15:0] sts_clear(
		input logic [15:0] old_val,
		input logic [15:0] wdata,
		input logic [15:0] lanes
	);
		logic [15:0] sel;
		sel = wdata & lanes & PCSR_STS_W1C;
		sts_clear = old_val & ~sel;
	endfunction

	// Next flags of one function; an event beats a clear in one cycle
	function automatic logic [15:0] sts_next(
		input logic [15:0] old_val,
		input logic wr,
		input logic [15:0] wdata,
		input logic [15:0] lanes,
		input logic [15:0] evt
	);
		logic [15:0] v;
		v = old_val;
		if (wr) begin
			v = sts_clear(old_val, wdata, lanes);
		end
		sts_next = v | evt;
	endfunction

	// Flags raised by one cycle of events for one function
	function automatic logic [15:0] evt_flags(
		input pcsr_evt_s e,
		input logic par_en,
		input logic serr_fire
	);
		logic [15:0] f;
		f = 16'h0000;
		// Detection is flagged even with both enables clear
		f[PCSR_S_PERR] = e.addr_parity_error_seen[0] |
			e.data_parity_error_seen;
		f[PCSR_S_SERR] = serr_fire;
		f[PCSR_S_MABT] = e.master_abort;
		f[PCSR_S_TABR] = e.target_abort_rx;
		f[PCSR_S_TABS] = e.target_abort_tx;
		// Only counts when we mastered the failing data phase
		f[PCSR_S_DPAR] = e.data_parity_error_seen &
			e.master_data_perr & par_en;
		evt_flags = f & PCSR_STS_W1C;
	endfunction

	// Single bit of a command word
	function automatic logic cmd_bit(
		input logic [15:0] c,
		input int pos
	);
		cmd_bit = c[pos];
	endfunction

	// Command word as the host reads it; every other bit is zero
	function automatic logic [15:0] cmd_view(
		input logic [15:0] c
	);
		logic [15:0] v;
		v = 16'h0000;
		v[PCSR_B_IO] = c[PCSR_B_IO];
		v[PCSR_B_MEM] = c[PCSR_B_MEM];
		v[PCSR_B_INIT] = c[PCSR_B_INIT];
		v[PCSR_B_PAR] = c[PCSR_B_PAR];
		v[PCSR_B_SYS] = c[PCSR_B_SYS];
		cmd_view = v;
	endfunction

	// Status word as the host reads it, fixed fields merged in
	function automatic logic [15:0] sts_view(
		input logic [15:0] s
	);
		logic [15:0] v;
		v = PCSR_STS_FIXED;
		v[PCSR_S_PERR] = s[PCSR_S_PERR];
		v[PCSR_S_SERR] = s[PCSR_S_SERR];
		v[PCSR_S_MABT] = s[PCSR_S_MABT];
		v[PCSR_S_TABR] = s[PCSR_S_TABR];
		v[PCSR_S_TABS] = s[PCSR_S_TABS];
		v[PCSR_S_DPAR] = s[PCSR_S_DPAR];
		sts_view = v;
	endfunction

	// One function's registers as the read port sees them
	function automatic logic [15:0] fn_read(
		input logic [7:0] addr,
		input logic [15:0] c,
		input logic [15:0] s
	);
		logic [15:0] v;
		case (addr)
			PCSR_OFS_CMD: begin
				v = cmd_view(c);
			end
			PCSR_OFS_STS: begin
				v = sts_view(s);
			end
			default: begin
				v = 16'h0000;
			end
		endcase
		fn_read = v;
	endfunction

	// Access strobe aimed at one register of one function
	function automatic logic hit(
		input logic strobe,
		input logic fn_sel,
		input logic fn,
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		hit = strobe && (fn_sel == fn) && (addr == ofs);
	endfunction

	// Error enables, per function and shared
	logic [15:0] wm;
	logic sys_en_f0;
	logic sys_en_f1;
	logic par_en_f0;
	logic par_en_f1;
	logic sys_en_any;
	logic par_en_any;
	logic addr_perr_any;
	logic data_perr_any;
	logic serr_fire;
	logic perr_fire;

	// Per-function working values
	logic wr_cmd_f0;
	logic wr_cmd_f1;
	logic wr_sts_f0;
	logic wr_sts_f1;
	logic [15:0] cmd_f0;
	logic [15:0] cmd_f1;
	logic [15:0] evt_f0;
	logic [15:0] evt_f1;
	logic [15:0] rd_f0;
	logic [15:0] rd_f1;
	logic [15:0] rd_word;

	always_comb begin
		s_nxt = s_r;
		wm = lane_mask(CFG_BE);

		// Per-function enables as software programmed them
		sys_en_f0 = cmd_bit(s_r.cmd_r[0], PCSR_B_SYS);
		sys_en_f1 = cmd_bit(s_r.cmd_r[1], PCSR_B_SYS);
		par_en_f0 = cmd_bit(s_r.cmd_r[0], PCSR_B_PAR);
		par_en_f1 = cmd_bit(s_r.cmd_r[1], PCSR_B_PAR);
		// One pair of error pins serves both functions
		sys_en_any = sys_en_f0 | sys_en_f1;
		par_en_any = par_en_f0 | par_en_f1;
		addr_perr_any = EVT_F0.addr_parity_error_seen[0] |
			EVT_F1.addr_parity_error_seen[0];
		data_perr_any = EVT_F0.data_parity_error_seen |
			EVT_F1.data_parity_error_seen;

		// Address parity reaches the pin only with both enables set
		serr_fire = addr_perr_any & sys_en_any &
			par_en_any;
		// With parity response off, detected errors do not drive the pin
		perr_fire = data_perr_any &
			par_en_any;
		s_nxt.serr_oe_r = serr_fire;
		s_nxt.perr_oe_r = perr_fire;

		// Strobes aimed at each register
		wr_cmd_f0 = hit(CFG_WR, CFG_FN, 1'b0,
			CFG_ADDR, PCSR_OFS_CMD);
		wr_cmd_f1 = hit(CFG_WR, CFG_FN, 1'b1,
			CFG_ADDR, PCSR_OFS_CMD);
		wr_sts_f0 = hit(CFG_WR, CFG_FN, 1'b0,
			CFG_ADDR, PCSR_OFS_STS);
		wr_sts_f1 = hit(CFG_WR, CFG_FN, 1'b1,
			CFG_ADDR, PCSR_OFS_STS);

		// Each function keeps its own command word
		cmd_f0 = cmd_next(s_r.cmd_r[0], wr_cmd_f0,
			CFG_WDATA, wm);
		cmd_f1 = cmd_next(s_r.cmd_r[1], wr_cmd_f1,
			CFG_WDATA, wm);
		s_nxt.cmd_r[0] = cmd_f0;
		s_nxt.cmd_r[1] = cmd_f1;

		// Events of each function land in its own flags, except SERR, which the shared serr_fire sets in both
		evt_f0 = evt_flags(EVT_F0, par_en_f0, serr_fire);
		evt_f1 = evt_flags(EVT_F1, par_en_f1, serr_fire);
		s_nxt.sts_r[0] = sts_next(s_r.sts_r[0], wr_sts_f0,
			CFG_WDATA, wm, evt_f0);
		s_nxt.sts_r[1] = sts_next(s_r.sts_r[1], wr_sts_f1,
			CFG_WDATA, wm, evt_f1);

		// Decode and mastering enables follow the new command word
		s_nxt.mem_en_r[0] = cmd_bit(cmd_f0, PCSR_B_MEM);
		s_nxt.mem_en_r[1] = cmd_bit(cmd_f1, PCSR_B_MEM);

		s_nxt.io_en_r[0] = cmd_bit(cmd_f0, PCSR_B_IO);
		s_nxt.io_en_r[1] = cmd_bit(cmd_f1, PCSR_B_IO);

		s_nxt.init_en_r[0] = cmd_bit(cmd_f0, PCSR_B_INIT);
		s_nxt.init_en_r[1] = cmd_bit(cmd_f1, PCSR_B_INIT);

		// Read data: unmapped offsets read zero
		rd_f0 = fn_read(CFG_ADDR, s_r.cmd_r[0], s_r.sts_r[0]);
		rd_f1 = fn_read(CFG_ADDR, s_r.cmd_r[1], s_r.sts_r[1]);
		if (CFG_FN) begin
			rd_word = rd_f1;
		end else begin
			rd_word = rd_f0;
		end
		// Read data stands until the next read
		if (CFG_RD) begin
			s_nxt.rdata_r = rd_word;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			s_r.cmd_r[0] <= PCSR_CMD_RST;
			s_r.cmd_r[1] <= PCSR_CMD_RST;
			// Flags come up clear; fixed fields are merged on read
			s_r.sts_r[0] <= PCSR_STS_RST & PCSR_STS_W1C;
			s_r.sts_r[1] <= PCSR_STS_RST & PCSR_STS_W1C;
			s_r.rdata_r <= 16'h0000;
			s_r.serr_oe_r <= 1'b0;
			s_r.perr_oe_r <= 1'b0;
			s_r.mem_en_r[0] <= 1'b0;
			s_r.mem_en_r[1] <= 1'b0;
			s_r.io_en_r[0] <= 1'b0;
			s_r.io_en_r[1] <= 1'b0;
			s_r.init_en_r[0] <= 1'b0;
			s_r.init_en_r[1] <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign CFG_RDATA = s_r.rdata_r;
	assign SERR_OE = s_r.serr_oe_r;
	assign PERR_OE = s_r.perr_oe_r;
	assign MEM_CLAIM_EN = s_r.mem_en_r;
	assign IO_CLAIM_EN = s_r.io_en_r;
	assign INITIATOR_EN = s_r.init_en_r;
endmodule
`default_nettype wire

// ==== bench/pcsr_regs_assertions.sv ====
// Checker bound into the command and status register bank
`timescale 1ns/1ps
`default_nettype none
module pcsr_chk import pcsr_pkg::*; (
	input wire logic REF_CLK, RST_B, CFG_WR, CFG_RD, CFG_FN, // bus
	input wire logic [7:0] CFG_ADDR, // offset
	input wire logic [1:0] CFG_BE, // byte enables
	input wire logic [15:0] CFG_WDATA, CFG_RDATA, // data
	input wire pcsr_evt_s EVT_F0, EVT_F1, // events
	input wire logic SERR_OE, PERR_OE, // drivers
	input wire logic [1:0] MEM_CLAIM_EN, IO_CLAIM_EN, INITIATOR_EN // enables
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	wire logic wc = CFG_WR && CFG_ADDR == PCSR_OFS_CMD;
	wire logic rc = CFG_RD && CFG_ADDR == PCSR_OFS_CMD;
	wire logic [5:0] en = {INITIATOR_EN, MEM_CLAIM_EN, IO_CLAIM_EN};
	property p_wr0; wc && !CFG_FN && CFG_BE[0] |=>
		{INITIATOR_EN[0], MEM_CLAIM_EN[0], IO_CLAIM_EN[0]} ==
		$past(CFG_WDATA[2:0]); endproperty
	a_wr0: assert property (p_wr0) else $error("fn0 enables");
	property p_wr1; wc && CFG_FN && CFG_BE[0] |=>
		MEM_CLAIM_EN[1] == $past(CFG_WDATA[1])
		&& $stable(MEM_CLAIM_EN[0]); endproperty
	a_wr1: assert property (p_wr1) else $error("fn1 enables");
	property p_hold; !wc |=> $stable(en); endproperty
	a_hold: assert property (p_hold) else $error("enable drift");
	property p_perr; PERR_OE |->
		$past(EVT_F0.data_parity_error_seen | EVT_F1.data_parity_error_seen); endproperty
	a_perr: assert property (p_perr) else $error("perr cause");
	property p_serr; SERR_OE |->
		$past(EVT_F0.addr_parity_error_seen[0] | EVT_F1.addr_parity_error_seen[0]); endproperty
	a_serr: assert property (p_serr) else $error("serr cause");
	property p_hi; rc |=> CFG_RDATA[15:10] == 6'h00; endproperty
	a_hi: assert property (p_hi) else $error("cmd upper");
	property p_ro; rc |=> (CFG_RDATA & 16'h02b8) == 16'h0000; endproperty
	a_ro: assert property (p_ro) else $error("cmd fixed");
	property p_sts; CFG_RD && CFG_ADDR == PCSR_OFS_STS |=>
		(CFG_RDATA & 16'h06ff) == 16'h0210; endproperty
	a_sts: assert property (p_sts) else $error("sts fixed");
endmodule
bind pcsr_regs pcsr_chk u_chk (.*);
`default_nettype wire

// ==== bench/pcsr_host.sv ====
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module pcsr_host (
	input wire logic REF_CLK, // bus clock
	input wire logic [15:0] CFG_RDATA, // read data
	output logic CFG_WR, CFG_RD, CFG_FN, // strobes, function
	output logic [7:0] CFG_ADDR, // offset
	output logic [15:0] CFG_WDATA, // write data
	output logic [1:0] CFG_BE // byte enables
);
	initial {CFG_WR, CFG_RD, CFG_FN, CFG_ADDR, CFG_WDATA, CFG_BE} = '0;
	// Stale write data is inverted so it never looks valid
	task xfer(input logic w, f, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge REF_CLK);
		#1 {CFG_WR, CFG_RD, CFG_FN, CFG_ADDR, CFG_WDATA, CFG_BE} =
			{w, !w, f, a, d, 2'h3};
		@(posedge REF_CLK);
		#1 {CFG_WR, CFG_RD} = 2'h0;
		CFG_WDATA = ~d;
		q = CFG_RDATA;
	endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the command and status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pcsr_pkg::*;
	logic REF_CLK = 1'h0, RST_B = 1'h0, CFG_WR, CFG_RD, CFG_FN;
	logic SERR_OE, PERR_OE;
	logic [7:0] CFG_ADDR;
	logic [15:0] CFG_WDATA, CFG_RDATA, q;
	logic [1:0] CFG_BE, MEM_CLAIM_EN, IO_CLAIM_EN, INITIATOR_EN;
	// Data parity as master, and address parity
	pcsr_evt_s EVT_F0 = '0, EVT_F1 = '0, dp = 21'h18, ap = 21'h20;
	// Master abort, target abort received and signalled
	pcsr_evt_s ab = 21'h07;
	int miscompares = 0, n_tests = 0, cyc = 0;
	initial forever #20 REF_CLK = ~REF_CLK;
	pcsr_regs DUT (.*);
	pcsr_host host (.*);
	function logic [15:0] o;
		return {8'h00, SERR_OE, PERR_OE, MEM_CLAIM_EN, IO_CLAIM_EN,
			INITIATOR_EN};
	endfunction
	task chk(input string s, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task conclude;
		$display("Checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task r(input logic f, input logic [7:0] a, input logic [15:0] e);
		host.xfer(1'h0, f, a, 16'h0000, q);
		chk($sformatf("read %h fn %h", a, f), q, e);
	endtask
	task w(input logic f, input logic [7:0] a, input logic [15:0] d);
		host.xfer(1'h1, f, a, d, q);
	endtask
	task ev(input pcsr_evt_s a, b, input logic [15:0] e);
		@(posedge REF_CLK);
		#1 {EVT_F0, EVT_F1} = {a, b};
		@(posedge REF_CLK);
		#1 {EVT_F0, EVT_F1} = '0;
		chk("outputs", o(), e);
	endtask
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 500) begin
			miscompares++;
			conclude;
		end
	end
	initial begin
		repeat (6) @(posedge REF_CLK);
		#1 RST_B = 1'h1;
		chk("outputs", o(), 16'h0000);
		r(1'h0, PCSR_OFS_CMD, 16'h0000);
		r(1'h1, PCSR_OFS_STS, 16'h0210);
		w(1'h0, PCSR_OFS_CMD, 16'hffff);
		r(1'h0, PCSR_OFS_CMD, 16'h0147);
		r(1'h1, PCSR_OFS_CMD, 16'h0000);
		chk("outputs", o(), 16'h0015);
		ev(dp, '0, 16'h0055);
		r(1'h0, PCSR_OFS_STS, 16'h8310);
		r(1'h1, PCSR_OFS_STS, 16'h0210);
		ev(ap, '0, 16'h0095);
		r(1'h1, PCSR_OFS_STS, 16'h4210);
		w(1'h0, PCSR_OFS_STS, 16'h4000);
		r(1'h0, PCSR_OFS_STS, 16'h8310);
		w(1'h0, PCSR_OFS_STS, 16'hffff);
		r(1'h0, PCSR_OFS_STS, 16'h0210);
		w(1'h0, PCSR_OFS_CMD, 16'h0100);
		w(1'h1, PCSR_OFS_CMD, 16'h0040);
		ev(ap, '0, 16'h0080);
		w(1'h1, PCSR_OFS_CMD, 16'h0000);
		ev(ap, dp, 16'h0000);
		ev('0, ab, 16'h0000);
		r(1'h1, PCSR_OFS_STS, 16'hfa10);
		w(1'h1, PCSR_OFS_STS, 16'hffff);
		r(1'h1, PCSR_OFS_STS, 16'h0210);
		conclude;
	end
endmodule
`default_nettype wire
